/* include/scb_pkg.sv */
// Constants and types for the slope-compensation configuration bank
// ============================================================
// Summary of operation
// - Reserved upper bits of every bank register ignore writes and read zero.
// - Four, three, two phase rates carry a four-bit capacitor code at 9:6.
// - Every rate register has a six-bit current code in bits 5:0.
// - Slew rate equals 16892 times current code over sixteen minus cap code.
// - Ten-bit clamp count, 5 ns steps, used while four phases run.
// - Separate ten-bit clamp count, 5 ns steps, used while three phases run.
// - Separate ten-bit clamp count, 5 ns steps, used while two phases run.
// - Separate ten-bit clamp count, 5 ns steps, for one-phase continuous mode.
// - When the active clamp timer expires the ramp stops and stays clamped.
// - One-phase continuous rate has one cap bit at 6, reserved 15:7.
// - Discontinuous rate holds only the current code; cap counts as zero.
// - These settings act on rail one only, never on the second rail.
// - Ten-bit clamp count, 5 ns steps, for one-phase discontinuous mode.
package scb_pkg;

  // ============================================================
  // Command codes (page 0)
  localparam logic [7:0] CMD_SLOPE_RATE_FOUR_PHASE     = 8'hD4;
  localparam logic [7:0] CMD_CLAMP_TIME_FOUR_PHASE     = 8'hD5;
  localparam logic [7:0] CMD_SLOPE_RATE_THREE_PHASE    = 8'hD6;
  localparam logic [7:0] CMD_CLAMP_TIME_THREE_PHASE    = 8'hD7;
  localparam logic [7:0] CMD_SLOPE_RATE_TWO_PHASE      = 8'hD8;
  localparam logic [7:0] CMD_CLAMP_TIME_TWO_PHASE      = 8'hD9;
  localparam logic [7:0] CMD_SLOPE_RATE_ONE_PHASE_CONT = 8'hDA;
  localparam logic [7:0] CMD_CLAMP_TIME_ONE_PHASE_CONT = 8'hDB;
  localparam logic [7:0] CMD_SLOPE_RATE_DISCONTINUOUS  = 8'hDC;
  localparam logic [7:0] CMD_CLAMP_TIME_DISCONTINUOUS  = 8'hDD;
  localparam int         NUM_REGS   = 10;
  localparam logic [2:0] BANK_PAGE  = 3'h0;

  // ============================================================
  // Writable-bit masks; everything else is reserved
  localparam logic [15:0] MASK_RATE_WIDE = 16'h03FF;
  localparam logic [15:0] MASK_RATE_1P   = 16'h007F;
  localparam logic [15:0] MASK_RATE_DCM  = 16'h003F;
  localparam logic [15:0] MASK_CLAMP     = 16'h03FF;
  localparam logic [15:0] REG_RESET_VAL  = 16'h0000;

  // ============================================================
  // Field positions
  localparam int CUR_LSB   = 0;
  localparam int CUR_W     = 6;
  localparam int CAP_LSB   = 6;
  localparam int CAP_W     = 4;
  localparam int CLAMP_W   = 10;

  // ============================================================
  // Slew-rate model and timing
  localparam logic [14:0] SLEW_GAIN     = 15'h41FC;  // 16892 V/s per code
  localparam logic [4:0]  CAP_FULL      = 5'h10;     // 16
  localparam int          SLEW_W        = 21;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          CLAMP_STEP_NS = 5;
  localparam int          CLAMP_STEP_CYC =
    (CLAMP_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Operating point selects a register pair: index of rate register
  localparam logic [3:0] IDX_FOUR  = 4'h0;
  localparam logic [3:0] IDX_THREE = 4'h2;
  localparam logic [3:0] IDX_TWO   = 4'h4;
  localparam logic [3:0] IDX_ONE   = 4'h6;
  localparam logic [3:0] IDX_DCM   = 4'h8;

  typedef enum logic [1:0] {
    SCB_RAMP  = 2'b01,
    SCB_CLAMP = 2'b10
  } scb_ramp_e;

endpackage

/* logic/scb_config_bank.sv */
// Rail one slope-compensation register bank with ramp clamp timer
module scb_config_bank
  import scb_pkg::*;
#(
  parameter int STEP_CYCLES = CLAMP_STEP_CYC
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Management-bus command port (decoded command code and page)
  input  wire logic [2:0]           cmdPage,
  input  wire logic [7:0]           cmdCode,
  input  wire logic                 cmdWrite,
  input  wire logic                 cmdRead,
  input  wire logic [15:0]          cmdWrData,
  output logic      [15:0]          cmdRdData,
  output logic                      cmdAck,
  output logic                      cmdHit,
  // Rail one operating point from the core
  input  wire logic [2:0]           rail1PhaseCount,
  input  wire logic                 rail1Discontinuous,
  input  wire logic                 rail1SlopeReset,
  // Settings driven to the rail one slope generator
  output logic [CAP_W-1:0]          slope_capacitor_code,
  output logic [CUR_W-1:0]          slopeCurrentCode,
  output logic [SLEW_W-1:0]         slopeSlewRate,
  output logic [CLAMP_W-1:0]        ramp_clamp_count,
  output logic                      rampActive,
  output logic                      rampClamped
);

  // ============================================================
  // Elaboration checks
  if (STEP_CYCLES < 1)
    $error("STEP_CYCLES must be at least one");

  // The step divider is 16 bits wide, so longer steps cannot be counted
  if (STEP_CYCLES > 65536)
    $error("STEP_CYCLES must fit the step divider");

  // The pair decode assumes ten words, a rate then a clamp per point
  if (NUM_REGS != 10)
    $error("NUM_REGS must be ten for the pair decode");

  // ============================================================
  // Helper functions

  // Writable bits per register index; reserved bits stay zero
  // Odd indices are clamp counts, even ones slope-rate registers
  function automatic logic [15:0] regMask(input logic [3:0] idx);
    logic [15:0] m;
    m = MASK_CLAMP;
    if (!idx[0])
    begin
      case (idx)
        IDX_ONE: m = MASK_RATE_1P;
        IDX_DCM: m = MASK_RATE_DCM;
        default: m = MASK_RATE_WIDE;
      endcase
    end
    return m;
  endfunction

  // Slew model: gain * current / (16 - cap)
  // Worst numerator is 16892 * 63, which still fits the 21-bit result;
  // the cap code stops at 15, so the divisor is never zero
  function automatic logic [SLEW_W-1:0] slewOf(
    input logic [CUR_W-1:0] cur,
    input logic [CAP_W-1:0] cap
  );
    logic [SLEW_W-1:0] num;
    logic [SLEW_W-1:0] den;
    num = SLEW_W'(SLEW_GAIN) * SLEW_W'(cur);
    den = SLEW_W'(CAP_FULL) - SLEW_W'(cap);
    return num / den;
  endfunction

  // ============================================================
  // Register storage and command decode
  // Ten 16-bit words held in flops; too few for a memory macro to pay,
  // and flops let the generator read two words in the same cycle
  logic [15:0] regs_q [NUM_REGS];
  logic [15:0] regs_d [NUM_REGS];
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;
  logic        ack_q;
  logic        ack_d;
  logic        hit_q;
  logic        hit_d;
  logic        inRange;
  logic [3:0]  cmdIdx;
  logic [7:0]  cmdOff;

  // Only page 0 codes D4h..DDh belong to this bank
  // Codes below D4h wrap in the subtraction; inRange keeps them out
  always_comb
  begin
    cmdOff  = cmdCode - CMD_SLOPE_RATE_FOUR_PHASE;
    cmdIdx  = cmdOff[3:0];
    inRange = (cmdPage == BANK_PAGE)
            && (cmdCode >= CMD_SLOPE_RATE_FOUR_PHASE)
            && (cmdCode <= CMD_CLAMP_TIME_DISCONTINUOUS);
  end

  // Writes keep only the defined field bits
  // Masking on entry means no later reader can see a reserved bit,
  // so neither the read path nor the generator needs its own gating
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
      regs_d[i] = regs_q[i];
    if (cmdWrite && inRange)
      regs_d[cmdIdx] = cmdWrData & regMask(cmdIdx);
  end

  // Reads answer one cycle later; unmapped codes return zero
  // Read data holds until the next read, for a host that samples late;
  // a write never disturbs it
  always_comb
  begin
    ack_d    = cmdWrite || cmdRead;
    hit_d    = inRange && (cmdWrite || cmdRead);
    rdData_d = rdData_q;
    if (cmdRead)
      rdData_d = inRange ? (regs_q[cmdIdx] & regMask(cmdIdx))
                         : 16'h0000;
  end

  // Bank registers
  // All words reset to zero: the smallest rate and the shortest clamp,
  // so an unconfigured rail clamps at once instead of ramping freely
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET_VAL;
      rdData_q <= 16'h0000;
      ack_q    <= 1'b0;
      hit_q    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= regs_d[i];
      rdData_q <= rdData_d;
      ack_q    <= ack_d;
      hit_q    <= hit_d;
    end
  end

  // Bus answers come straight from flops
  assign cmdRdData = rdData_q;
  assign cmdAck    = ack_q;
  assign cmdHit    = hit_q;

  // ============================================================
  // Operating-point selection; phase counts above four use the
  // four-phase pair since no other pair exists in this bank.
  // A mode change mid-ramp applies the new limit one cycle later; the elapsed
  // count is kept, so the ramp is not restarted by the change
  logic [3:0]         selIdx;
  logic [15:0]        selRate;
  logic [15:0]        selClamp;

  always_comb
  begin
    if (rail1Discontinuous)
      selIdx = IDX_DCM;
    else
    begin
      case (rail1PhaseCount)
        3'h1:    selIdx = IDX_ONE;
        3'h2:    selIdx = IDX_TWO;
        3'h3:    selIdx = IDX_THREE;
        default: selIdx = IDX_FOUR;
      endcase
    end
    selRate  = regs_q[selIdx];
    selClamp = regs_q[selIdx + 4'h1];
  end

  // Settings go to the rail one generator only
  // The second rail has no port here, so nothing in this bank reaches it
  logic [CAP_W-1:0]   cap_q;
  logic [CAP_W-1:0]   cap_d;
  logic [CUR_W-1:0]   cur_q;
  logic [CUR_W-1:0]   cur_d;
  logic [SLEW_W-1:0]  slew_q;
  logic [SLEW_W-1:0]  slew_d;
  logic [CLAMP_W-1:0] limit_q;
  logic [CLAMP_W-1:0] limit_d;

  // Masked storage makes the one-phase cap a single bit and DCM cap zero
  // so no extra gating is needed on the selected fields
  always_comb
  begin
    cap_d   = selRate[CAP_LSB +: CAP_W];
    cur_d   = selRate[CUR_LSB +: CUR_W];
    slew_d  = slewOf(cur_d, cap_d);
    limit_d = selClamp[CLAMP_W-1:0];
  end

  // Registered so the divider path never reaches the outputs
  // Costs one cycle of latency after a mode or register change
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_q   <= '0;
      cur_q   <= '0;
      slew_q  <= '0;
      limit_q <= '0;
    end
    else
    begin
      cap_q   <= cap_d;
      cur_q   <= cur_d;
      slew_q  <= slew_d;
      limit_q <= limit_d;
    end
  end

  // Generator settings, all from flops
  assign slope_capacitor_code = cap_q;
  assign slopeCurrentCode     = cur_q;
  assign slopeSlewRate        = slew_q;
  assign ramp_clamp_count     = limit_q;

  // ============================================================
  // Clamp timer: one count per 5 ns step after each slope reset
  // The limit is read live each cycle, so a register write during
  // a ramp moves the clamp point; a limit of zero clamps at once
  scb_ramp_e          state_q;
  scb_ramp_e          state_d;
  logic [CLAMP_W-1:0] elapsed_q;
  logic [CLAMP_W-1:0] elapsed_d;
  logic [15:0]        div_q;
  logic [15:0]        div_d;
  logic               stepEn;

  // Step divider restarts with the ramp so every step is whole
  // With a one-cycle step the divider stays at zero and stepEn is
  // always high, which costs nothing and keeps one code path
  always_comb
  begin
    stepEn = (div_q == 16'(STEP_CYCLES - 1));
    if (rail1SlopeReset || stepEn)
      div_d = 16'h0000;
    else
      div_d = div_q + 16'h0001;
  end

  // Ramp grows until the selected count expires, then holds
  // Lowering the limit below the elapsed count clamps on the next
  // cycle; only a slope reset can release the clamp
  always_comb
  begin
    state_d   = state_q;
    elapsed_d = elapsed_q;
    if (rail1SlopeReset)
    begin
      state_d   = SCB_RAMP;
      elapsed_d = '0;
    end
    else
    begin
      case (state_q)
        SCB_RAMP:
        begin
          if (elapsed_q >= limit_q)
            state_d = SCB_CLAMP;
          else if (stepEn)
            elapsed_d = elapsed_q + 1'b1;
        end
        SCB_CLAMP: state_d = SCB_CLAMP;
        default:   state_d = SCB_CLAMP;
      endcase
    end
  end

  // Starts clamped so no ramp runs before the first reset
  // The state flop is the only source of both ramp outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= SCB_CLAMP;
      elapsed_q <= '0;
      div_q     <= 16'h0000;
    end
    else
    begin
      state_q   <= state_d;
      elapsed_q <= elapsed_d;
      div_q     <= div_d;
    end
  end

  // Ramp status straight from the one-hot state register
  assign rampActive  = (state_q == SCB_RAMP);
  assign rampClamped = (state_q == SCB_CLAMP);

endmodule // scb_config_bank

/* test/scb_config_bank_properties.sv */
// Port-level assertions for the slope bank
module scb_config_bank_properties
  import scb_pkg::*;
#(
  parameter int STEP_CYCLES = 1
)(
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic [2:0]         cmdPage,
  input wire logic               cmdRead,
  input wire logic [15:0]        cmdRdData,
  input wire logic               cmdHit,
  input wire logic [2:0]         rail1PhaseCount,
  input wire logic               rail1Discontinuous,
  input wire logic               rail1SlopeReset,
  input wire logic [CAP_W-1:0]   slope_capacitor_code,
  input wire logic [CUR_W-1:0]   slopeCurrentCode,
  input wire logic [SLEW_W-1:0]  slopeSlewRate,
  input wire logic [CLAMP_W-1:0] ramp_clamp_count,
  input wire logic               rampActive,
  input wire logic               rampClamped
);
  // ============================================================
  // Reference slew; cap never exceeds 15, so no divide by zero
  logic [SLEW_W-1:0] slewRef;
  always_comb slewRef = 21'(16892 * slopeCurrentCode
                        / (16 - slope_capacitor_code));
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Slope reset followed by three cycles of a limit of 3 or more
  sequence rampStart;
    rail1SlopeReset ##1 (!rail1SlopeReset && ramp_clamp_count >= 10'h003)[*3];
  endsequence
  chk_rsvd_read_zero: assert property (cmdRdData[15:10] == 6'h00)
    else $error("reserved read bits set");
  chk_other_page: assert property (cmdRead && cmdPage != 3'h0 |=>
    !cmdHit && cmdRdData == 16'h0000) else $error("foreign page answered");
  chk_dcm_no_cap: assert property ($past(rail1Discontinuous) |->
    slope_capacitor_code == 4'h0) else $error("cap code in DCM");
  chk_one_phase_cap: assert property ($past(rail1PhaseCount) == 3'h1
    && !$past(rail1Discontinuous) |-> slope_capacitor_code <= 4'h1)
    else $error("wide cap code in one phase");
  chk_slew_formula: assert property ($stable(slopeCurrentCode)
    && $stable(slope_capacitor_code) |-> slopeSlewRate == slewRef)
    else $error("slew rate wrong");
  chk_reset_starts: assert property (rail1SlopeReset |=>
    rampActive && !rampClamped) else $error("ramp did not restart");
  chk_clamp_holds: assert property (rampClamped && !rail1SlopeReset
    |=> rampClamped) else $error("clamp released early");
  chk_zero_limit: assert property (rampActive && !rail1SlopeReset
    && ramp_clamp_count == 10'h000 |=> rampClamped)
    else $error("zero limit did not clamp");
  chk_no_early_clamp: assert property (rampStart |=> rampActive)
    else $error("ramp clamped early");
endmodule // scb_config_bank_properties

bind scb_config_bank scb_config_bank_properties #(
  .STEP_CYCLES(STEP_CYCLES)
) i_props (.*);

/* test/scb_host_model.sv */
// Management-bus host model for the bank command port
module scb_host_model (
  input  wire logic        sys_clk,
  output logic [2:0]       cmdPage,
  output logic [7:0]       cmdCode,
  output logic             cmdWrite,
  output logic             cmdRead,
  output logic [15:0]      cmdWrData,
  input  wire logic [15:0] cmdRdData,
  input  wire logic        cmdAck,
  input  wire logic        cmdHit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Idle state at time zero
  initial
  begin
    cmdPage = 3'h0;
    cmdCode = 8'h00;
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdWrData = 16'h0000;
  end
  // One-cycle strobe, then a bounded wait for the acknowledge
  task automatic xfer(input logic w, input logic [2:0] pg,
                      input logic [7:0] cd, input logic [15:0] wd,
                      output logic [15:0] rd, output logic hit);
    int n;
    @(negedge sys_clk);
    cmdPage = pg;
    cmdCode = cd;
    cmdWrData = wd;
    cmdWrite = w;
    cmdRead = !w;
    @(negedge sys_clk);
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdCode = ~cd;   // Released lines toggle so stale values never match
    cmdWrData = ~wd;
    n = 0;
    while (cmdAck !== 1'b1 && n < 3)
    begin
      @(negedge sys_clk);
      n++;
    end
    rd = (cmdAck === 1'b1) ? cmdRdData : 16'hXXXX; // No answer never matches
    hit = cmdAck & cmdHit;
  endtask
endmodule // scb_host_model

/* test/testbench.sv */
// Self-checking bench for the slope bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scb_pkg::*;
  // ============================================================
  // Signals and bookkeeping
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  cmdPage, rail1PhaseCount;
  logic [7:0]  cmdCode;
  logic        cmdWrite, cmdRead, cmdAck, cmdHit, rampActive, rampClamped;
  logic [15:0] cmdWrData, cmdRdData, rd;
  logic        rail1Discontinuous, rail1SlopeReset, hit;
  logic [3:0]  capCode;
  logic [5:0]  curCode;
  logic [20:0] slew;
  logic [9:0]  clampCnt;
  logic [15:0] sh [10];
  int          seed = 71, n_mismatch = 0, compares = 0;
  int          offTime, clampLim;
  always #2.5 sys_clk = ~sys_clk;
  scb_config_bank #(.STEP_CYCLES(1)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .cmdPage(cmdPage), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
    .cmdRead(cmdRead), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData),
    .cmdAck(cmdAck), .cmdHit(cmdHit), .rail1PhaseCount(rail1PhaseCount),
    .rail1Discontinuous(rail1Discontinuous),
    .rail1SlopeReset(rail1SlopeReset), .slope_capacitor_code(capCode),
    .slopeCurrentCode(curCode), .slopeSlewRate(slew),
    .ramp_clamp_count(clampCnt), .rampActive(rampActive),
    .rampClamped(rampClamped));
  scb_host_model i_host (.sys_clk(sys_clk), .cmdPage(cmdPage),
    .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdAck(cmdAck),
    .cmdHit(cmdHit));
  // Compare and count
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Writable bits: one-phase rate 6:0, DCM rate 5:0, others 9:0
  function automatic logic [15:0] wmask(input int i);
    return i == 6 ? 16'h007F : i == 8 ? 16'h003F : 16'h03FF;
  endfunction
  task automatic wr(input int i, input logic [15:0] d);
    i_host.xfer(1'b1, 3'h0, 8'hD4 + 8'(i), d, rd, hit);
    sh[i] = d & wmask(i);
    chk(hit, 1'b1);
  endtask
  task automatic rdc(input int i);
    i_host.xfer(1'b0, 3'h0, 8'hD4 + 8'(i), 16'h0000, rd, hit);
    chk(rd, sh[i]);
    chk(hit, 1'b1);
  endtask
  // Pick an operating point and check the selected pair
  task automatic sel(input int m, input int pc);
    logic [15:0] r;
    logic [3:0]  c;
    @(negedge sys_clk);
    rail1Discontinuous = (m == 4);
    rail1PhaseCount = 3'(pc);
    repeat (2) @(negedge sys_clk);
    r = sh[2 * m];
    c = m < 3 ? r[9:6] : m == 3 ? {3'h0, r[6]} : 4'h0;
    chk(capCode, c);
    chk(curCode, r[5:0]);
    chk(slew, 21'(16892 * r[5:0] / (16 - c)));
    chk(clampCnt, sh[2 * m + 1][9:0]);
  endtask
  task automatic pulse;
    @(negedge sys_clk);
    rail1SlopeReset = 1'b1;
    @(negedge sys_clk);
    rail1SlopeReset = 1'b0;
  endtask
  // Time from ramp start to clamp; optional restart mid-ramp
  task automatic ramp(input int m, input int lim, input bit again);
    int n;
    wr(2 * m + 1, 16'(lim));
    if (again)
    begin
      pulse();
      repeat (2) @(negedge sys_clk);
    end
    pulse();
    chk(rampActive, 1'b1);
    n = 0;
    while (rampClamped !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(21'(n), 21'(lim + 1));
    chk(rampActive, 1'b0);
  endtask
  task automatic test_done;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    rail1PhaseCount = 3'h4;
    rail1Discontinuous = 1'b0;
    rail1SlopeReset = 1'b0;
    sh = '{default: 16'h0000};
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 10; i++)
      rdc(i);
    $display("test reset_values done");
    for (int r = 0; r < 4; r++)
    begin
      for (int i = 0; i < 10; i++)
        wr(i, r == 0 ? 16'hFFFF : 16'($random(seed)));
      for (int i = 0; i < 10; i++)
        rdc(i);
    end
    $display("test read_write done");
    i_host.xfer(1'b1, 3'h1, 8'hD4, 16'h0155, rd, hit);
    chk(hit, 1'b0);
    i_host.xfer(1'b0, 3'h1, 8'hD4, 16'h0000, rd, hit);
    chk({hit, rd}, 17'h00000);
    i_host.xfer(1'b0, 3'h0, 8'hDE, 16'h0000, rd, hit);
    chk({hit, rd}, 17'h00000);
    rdc(0);
    $display("test unmapped done");
    // Clamp limits follow host guidance: 1.3x off-time, 1.1x in DCM, zero on the first four-phase run
    for (int m = 0; m < 6; m++)
    begin
      offTime = 3 + ($random(seed) & 31);
      clampLim = m == 0 ? 0 : (m == 4 ? offTime * 11 : offTime * 13) / 10;
      sel(m % 5, m == 5 ? 6 : 4 - m);
      ramp(m % 5, clampLim, m == 5);
    end
    $display("test modes_and_clamp done");
    test_done();
  end
endmodule // testbench
